// file: common/ccr_params.svh
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

// channel count and command bytes of the register bank
`define CCR_NUM_CH        4
`define CCR_CMD_ASG_FIRST 8'h4C
`define CCR_CMD_ASG_LAST  8'h4F
`define CCR_CMD_ACTRL     8'h50

// field positions inside the class and control bytes
`define CCR_GRANT_HI      7
`define CCR_GRANT_LO      4
`define CCR_EARLY_HI      3
`define CCR_EARLY_LO      0
`define CCR_PROBE_LO      4

// reset values
`define CCR_CLASS_RST     8'h00
`define CCR_ACTRL_RST     8'h00

// class codes
`define CCR_CODE_NONE     4'h0
`define CCR_CODE_CLASS0   4'h6
`define CCR_CODE_CLASS3   4'h3
`define CCR_CODE_DUAL5    4'hD
`define CCR_CODE_SS_OFS   4'h3
`define CCR_CLS_MAX_2P    4'h4
`define CCR_CLS_5         4'h5
`define CCR_CLS_8         4'h8

// timing: probe start limit in ms, clock in kHz
`define CCR_PROBE_START_MS 10
`define CCR_CLK_KHZ        125000

`endif

// file: common/ccr_pkg.sv
package ccr_pkg;

    // per-channel status from the port controller, same clock
    typedef struct packed {
        logic       turn_on;            // pulse: channel powered up
        logic       turn_off;           // pulse: channel turned off
        logic       class_measured;     // pulse: classification measured here
        logic [3:0] granted_class;      // class after power allocation, 0..8
        logic       four_pair_single;   // single-signature four-pair device
        logic       dual_sig;           // dual-signature four-pair device
        logic       one_finger_limited; // 15.4 W limit, one finger at turn-on
        logic       semi_auto;          // channel in semi-auto mode
        logic       detect_enable_bit;  // detection enabled
        logic       class_enable_bit;   // classification enabled
        logic [3:0] three_finger_class; // preceding three-finger result, 0..8
        logic       probe_written;      // pulse: power result stored
    } ccr_chan_in_type;

    // command-byte register access from the serial bus engine
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] cmd;
        logic [7:0] wdata;
    } ccr_reg_req_type;

    typedef ccr_chan_in_type [3:0] ccr_chan_arr_type;
    typedef logic [7:0] ccr_byte_arr_type [0:3];

endpackage

// file: logic/ccr_class_report.sv
// Operation
// - upper nibble granted class, read-only, reset zero
// - lower nibble earlier class, read-only, reset zero
// - granted class is allocation-limited power-up class
// - single-signature pair mirrors granted class promptly
// - only measured channel raises class done event
// - dual-signature channels report own class promptly
// - class 0 signature recorded as class 3 in granted nibble
// - limited semi-auto turn-on keeps three-finger class
// - control byte: probe requests high, autotune low
// - probe request starts measurement within 10 ms
// - probe request cleared after result is written
// - autotune set recomputes power cut threshold
// - turn-off clears both class nibbles
// - probe requests pending at turn-on are dropped
`timescale 1ns/10ps
`include "ccr_params.svh"

module ccr_class_report #(
    parameter int unsigned PROBE_START_CYC = `CCR_PROBE_START_MS * `CCR_CLK_KHZ
) (
    input  wire logic                      clk_in,
    input  wire logic                      reset_in,
    input  wire ccr_pkg::ccr_reg_req_type  reg_req_in,
    input  wire ccr_pkg::ccr_chan_arr_type chan_in,
    output logic [7:0]                     rd_data_out,
    output logic                           rd_valid_out,
    output logic [3:0]                     class_done_event_out,
    output logic [3:0]                     probe_start_out,
    output logic [3:0]                     pcut_recompute_out
);
    import ccr_pkg::*;

    // granted code from allocated class; reserved codes never produced
    function automatic logic [3:0] enc_grant(input logic [3:0] cls, input logic single, input logic dual);
        logic [3:0] code;
        code = `CCR_CODE_NONE;
        if (cls == 4'h0) begin
            code = `CCR_CODE_CLASS3;
        end else if (cls <= `CCR_CLS_MAX_2P) begin
            code = cls;
        end else if (cls == `CCR_CLS_5 && dual) begin
            code = `CCR_CODE_DUAL5;
        end else if (cls <= `CCR_CLS_8 && single && !dual) begin
            // classes 6..8 exist only as four-pair single codes, class 5 also as the dual code; a two-pair claim stays empty
            code = cls + `CCR_CODE_SS_OFS;
        end
        return code;
    endfunction

    // earlier-class code: same table but class 0 has its own code
    function automatic logic [3:0] enc_early(input logic [3:0] cls, input logic single, input logic dual);
        logic [3:0] code;
        code = (cls == 4'h0) ? `CCR_CODE_CLASS0 : enc_grant(cls, single, dual);
        return code;
    endfunction

    // legal code check, shared by the assertions
    function automatic logic legal_code(input logic [3:0] code, input logic early);
        logic ok;
        ok = (code <= `CCR_CLS_MAX_2P) || (code >= 4'h8 && code <= 4'hB) || (code == `CCR_CODE_DUAL5);
        if (code == `CCR_CODE_NONE) begin
            ok = 1'b1;
        end else if (code == `CCR_CODE_CLASS0) begin
            ok = early;
        end
        return ok;
    endfunction

    ccr_byte_arr_type class_reg;       // per-channel class bytes
    ccr_byte_arr_type next_class_reg;
    logic [7:0]       actrl;           // probe requests and autotune enables
    logic [7:0]       next_actrl;
    logic [3:0]       powered;         // channel currently on
    logic [3:0]       next_powered;
    logic [3:0]       started;         // probe already launched for request
    logic [3:0]       next_started;
    logic [7:0]       next_rd_data;
    logic             next_rd_valid;
    logic [3:0]       next_done_evt;
    logic [3:0]       next_probe_start;
    logic [3:0]       next_recompute;

    // next-state logic for the whole bank
    always_comb begin
        int unsigned pr;
        pr               = 0;
        next_class_reg   = class_reg;
        next_actrl       = actrl;
        next_powered     = powered;
        next_started     = started;
        next_done_evt    = '0;
        next_probe_start = '0;
        next_recompute   = '0;
        for (int ch = 0; ch < `CCR_NUM_CH; ch++) begin
            pr = ch ^ 1;
            // only the measuring channel flags completion
            next_done_evt[ch] = chan_in[ch].class_measured;
            if (chan_in[ch].turn_off) begin
                // off wipes both results and the probe-launched flag; the request bit stays
                next_class_reg[ch] = `CCR_CLASS_RST;
                next_powered[ch]   = 1'b0;
                next_started[ch]   = 1'b0;
            end else if (chan_in[ch].turn_on) begin
                next_powered[ch] = 1'b1;
                next_class_reg[ch][`CCR_GRANT_HI:`CCR_GRANT_LO] =
                    enc_grant(chan_in[ch].granted_class, chan_in[ch].four_pair_single,
                              chan_in[ch].dual_sig);
                if (chan_in[ch].four_pair_single) begin
                    // partner mirrors in the same cycle, well inside the limit
                    next_class_reg[pr][`CCR_GRANT_HI:`CCR_GRANT_LO] =
                        enc_grant(chan_in[ch].granted_class, 1'b1, 1'b0);
                end
                if (chan_in[ch].one_finger_limited && chan_in[ch].semi_auto &&
                    chan_in[ch].detect_enable_bit && chan_in[ch].class_enable_bit) begin
                    next_class_reg[ch][`CCR_EARLY_HI:`CCR_EARLY_LO] =
                        enc_early(chan_in[ch].three_finger_class, chan_in[ch].four_pair_single,
                                  chan_in[ch].dual_sig);
                end
                // stale requests must not fire a probe on a fresh channel
                next_actrl[`CCR_PROBE_LO + ch] = 1'b0;
                next_started[ch]               = 1'b0;
            end
            if (chan_in[ch].probe_written) begin
                // autotune only when enabled; else threshold is left alone
                next_recompute[ch]             = actrl[ch];
                next_actrl[`CCR_PROBE_LO + ch] = 1'b0;
                next_started[ch]               = 1'b0;
            end else if (actrl[`CCR_PROBE_LO + ch] && powered[ch] && !started[ch] &&
                         !chan_in[ch].turn_on && !chan_in[ch].turn_off) begin
                next_probe_start[ch] = 1'b1;
                next_started[ch]     = 1'b1;
            end
        end
        // host write last so a set in the clearing cycle wins
        if (reg_req_in.wr && reg_req_in.cmd == `CCR_CMD_ACTRL) begin
            next_actrl = reg_req_in.wdata;
            for (int ch = 0; ch < `CCR_NUM_CH; ch++) begin
                if (!reg_req_in.wdata[`CCR_PROBE_LO + ch]) begin
                    next_started[ch] = 1'b0;
                end
            end
        end
        // reads answer one cycle later; class bytes ignore writes
        next_rd_valid = reg_req_in.rd;
        next_rd_data  = 8'h00;
        if (reg_req_in.rd) begin
            if (reg_req_in.cmd >= `CCR_CMD_ASG_FIRST && reg_req_in.cmd <= `CCR_CMD_ASG_LAST) begin
                next_rd_data = class_reg[reg_req_in.cmd[1:0]];
            end else if (reg_req_in.cmd == `CCR_CMD_ACTRL) begin
                next_rd_data = actrl;
            end
        end
    end

    // registers only
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            for (int ch = 0; ch < `CCR_NUM_CH; ch++) begin
                class_reg[ch] <= `CCR_CLASS_RST;
            end
            actrl                <= `CCR_ACTRL_RST;
            powered              <= '0;
            started              <= '0;
            rd_data_out          <= 8'h00;
            rd_valid_out         <= 1'b0;
            class_done_event_out <= '0;
            probe_start_out      <= '0;
            pcut_recompute_out   <= '0;
        end else begin
            class_reg            <= next_class_reg;
            actrl                <= next_actrl;
            powered              <= next_powered;
            started              <= next_started;
            rd_data_out          <= next_rd_data;
            rd_valid_out         <= next_rd_valid;
            class_done_event_out <= next_done_evt;
            probe_start_out      <= next_probe_start;
            pcut_recompute_out   <= next_recompute;
        end
    end

    // helper: cycles a powered channel 0 request has waited for its probe
    logic [31:0] wait_cnt;
    always_ff @(posedge clk_in) begin
        if (reset_in || !actrl[`CCR_PROBE_LO] || !powered[0] || started[0]) begin
            wait_cnt <= 32'h0;
        end else begin
            wait_cnt <= wait_cnt + 32'h1;
        end
    end

    property p_codes_legal;
        @(posedge clk_in) disable iff (reset_in)
        legal_code(class_reg[0][7:4], 1'b0) && legal_code(class_reg[0][3:0], 1'b1);
    endproperty
    a_codes_legal: assert property (p_codes_legal) else $error("reserved class code");

    property p_off_clears;
        @(posedge clk_in) disable iff (reset_in)
        chan_in[1].turn_off |=> class_reg[1] == `CCR_CLASS_RST;
    endproperty
    a_off_clears: assert property (p_off_clears) else $error("turn-off left class");

    property p_class0_as3;
        @(posedge clk_in) disable iff (reset_in)
        chan_in[0].turn_on && !chan_in[0].turn_off && chan_in[0].granted_class == 4'h0
        && !(chan_in[1].turn_on && chan_in[1].four_pair_single)
        |=> class_reg[0][`CCR_GRANT_HI:`CCR_GRANT_LO] == `CCR_CODE_CLASS3;
    endproperty
    a_class0_as3: assert property (p_class0_as3) else $error("class 0 not recorded as 3");

    property p_pair_mirror;
        @(posedge clk_in) disable iff (reset_in)
        chan_in[0].turn_on && chan_in[0].four_pair_single && !chan_in[0].turn_off && !chan_in[1].turn_on
        && !chan_in[1].turn_off
        |=> class_reg[1][`CCR_GRANT_HI:`CCR_GRANT_LO] == class_reg[0][`CCR_GRANT_HI:`CCR_GRANT_LO];
    endproperty
    a_pair_mirror: assert property (p_pair_mirror) else $error("pair classes differ");

    property p_done_own;
        @(posedge clk_in) disable iff (reset_in)
        chan_in[0].class_measured && !chan_in[1].class_measured |=> class_done_event_out[1:0] == 2'b01;
    endproperty
    a_done_own: assert property (p_done_own) else $error("wrong class done flag");

    property p_probe_clear;
        @(posedge clk_in) disable iff (reset_in)
        chan_in[0].probe_written && !(reg_req_in.wr && reg_req_in.cmd == `CCR_CMD_ACTRL)
        |=> !actrl[`CCR_PROBE_LO];
    endproperty
    a_probe_clear: assert property (p_probe_clear) else $error("probe request not cleared");

    property p_start_bound;
        @(posedge clk_in) disable iff (reset_in)
        wait_cnt < 32'(PROBE_START_CYC);
    endproperty
    a_start_bound: assert property (p_start_bound) else $error("probe start late");

    property p_autotune;
        @(posedge clk_in) disable iff (reset_in)
        chan_in[0].probe_written |=> pcut_recompute_out[0] == $past(actrl[0]);
    endproperty
    a_autotune: assert property (p_autotune) else $error("threshold recompute mismatch");

    property p_stale_drop;
        @(posedge clk_in) disable iff (reset_in)
        chan_in[0].turn_on && !chan_in[0].turn_off && !(reg_req_in.wr && reg_req_in.cmd == `CCR_CMD_ACTRL)
        |=> !actrl[`CCR_PROBE_LO] ##1 !probe_start_out[0];
    endproperty
    a_stale_drop: assert property (p_stale_drop) else $error("stale probe kept");

    c_probe_cycle: cover property (@(posedge clk_in) disable iff (reset_in)
        probe_start_out[0] ##[1:20] pcut_recompute_out[0]);
    c_early_kept: cover property (@(posedge clk_in) disable iff (reset_in) class_reg[1][3:0] != 4'h0);
    c_read_ctrl: cover property (@(posedge clk_in) disable iff (reset_in)
        rd_valid_out && rd_data_out != 8'h00);
endmodule

// file: test/ccr_host_model.sv
`timescale 1ns/10ps
// host on the management bus: one command byte per transfer
module ccr_host_model (
    input  wire logic                 clk_in,
    input  wire logic [7:0]           rd_data_in,
    input  wire logic                 rd_valid_in,
    output ccr_pkg::ccr_reg_req_type  reg_req_out
);
    import ccr_pkg::*;

    initial reg_req_out = '0;

    // released lines show the inverse of the last byte, never a stale copy
    task automatic drop_bus(input ccr_reg_req_type last);
        reg_req_out <= '{rd: 1'b0, wr: 1'b0, cmd: ~last.cmd, wdata: ~last.wdata};
    endtask

    // request held from one edge to the taking edge, then released
    task automatic write_reg(input logic [7:0] cmd, input logic [7:0] data);
        ccr_reg_req_type req;
        req = '{rd: 1'b0, wr: 1'b1, cmd: cmd, wdata: data};
        @(posedge clk_in);
        reg_req_out <= req;
        @(posedge clk_in);
        drop_bus(req);
    endtask

    // answer sampled at the edge after the taking edge
    task automatic read_reg(input logic [7:0] cmd, output logic [8:0] seen);
        ccr_reg_req_type req;
        req = '{rd: 1'b1, wr: 1'b0, cmd: cmd, wdata: 8'h00};
        @(posedge clk_in);
        reg_req_out <= req;
        @(posedge clk_in);
        drop_bus(req);
        @(posedge clk_in);
        seen = {rd_valid_in, rd_data_in};
    endtask
    // threshold upkeep with autotune clear is left to host software
    // earlier nibble trusted only for full semi-auto setup
endmodule

// file: test/ccr_class_report_tb.sv
`timescale 1ns/10ps
module ccr_class_report_tb;
    import ccr_pkg::*;

    // one channel-0 case: inputs and both expected class bytes
    typedef struct packed {
        logic [3:0] cls;
        logic       single;
        logic       dual;
        logic [3:0] cond;   // limited, semi, detect, class enables
        logic [3:0] three;
        logic [7:0] exp0;
        logic [7:0] exp1;
    } ccr_tb_row_type;

    logic             clk_in   = 1'b0;
    logic             reset_in = 1'b1;
    ccr_reg_req_type  reg_req;
    ccr_chan_arr_type chan     = '0;
    logic [7:0]       rd_data;
    logic             rd_valid;
    logic [3:0]       done_evt;
    logic [3:0]       probe_start;
    logic [3:0]       pcut;
    logic [8:0]       seen;
    int               errors      = 0;
    int               comparisons = 0;
    int               cycles      = 0;
    int               n_start     = 0;
    ccr_tb_row_type   rows [10] = '{
        '{4'h0, 1'b0, 1'b0, 4'hF, 4'h0, 8'h36, 8'h00},
        '{4'h1, 1'b0, 1'b0, 4'h0, 4'h0, 8'h10, 8'h00},
        '{4'h2, 1'b0, 1'b0, 4'hF, 4'h2, 8'h22, 8'h00},
        '{4'h4, 1'b0, 1'b0, 4'hF, 4'h7, 8'h40, 8'h00},
        '{4'h5, 1'b1, 1'b0, 4'hF, 4'h8, 8'h8B, 8'h80},
        '{4'h8, 1'b1, 1'b0, 4'h0, 4'h0, 8'hB0, 8'hB0},
        '{4'h6, 1'b1, 1'b0, 4'hF, 4'h0, 8'h96, 8'h90},
        '{4'h5, 1'b0, 1'b1, 4'hF, 4'h5, 8'hDD, 8'h00},
        '{4'h7, 1'b0, 1'b0, 4'h0, 4'h0, 8'h00, 8'h00},
        '{4'h3, 1'b0, 1'b0, 4'hB, 4'h4, 8'h30, 8'h00}};

    // 8 ns clock
    always #4 clk_in = ~clk_in;

    ccr_class_report #(.PROBE_START_CYC(16)) DUT (
        .clk_in               (clk_in),
        .reset_in             (reset_in),
        .reg_req_in           (reg_req),
        .chan_in              (chan),
        .rd_data_out          (rd_data),
        .rd_valid_out         (rd_valid),
        .class_done_event_out (done_evt),
        .probe_start_out      (probe_start),
        .pcut_recompute_out   (pcut)
    );

    ccr_host_model host (
        .clk_in      (clk_in),
        .rd_data_in  (rd_data),
        .rd_valid_in (rd_valid),
        .reg_req_out (reg_req)
    );

    task automatic finish_test;
        $display("counts: comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [8:0] got, input logic [8:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one-cycle channel pulses, channel 0 levels from the row
    task automatic fire(input logic [3:0] on, off, meas, wrt, input ccr_tb_row_type r);
        ccr_chan_arr_type v;
        v = '0;
        for (int i = 0; i < 4; i++) begin
            v[i].turn_on = on[i];
            v[i].turn_off = off[i];
            v[i].class_measured = meas[i];
            v[i].probe_written = wrt[i];
        end
        v[0].granted_class = r.cls;
        v[0].four_pair_single = r.single;
        v[0].dual_sig = r.dual;
        {v[0].one_finger_limited, v[0].semi_auto, v[0].detect_enable_bit, v[0].class_enable_bit} = r.cond;
        v[0].three_finger_class = r.three;
        @(posedge clk_in);
        chan <= v;
        @(posedge clk_in);
        chan <= '0;
    endtask

    task automatic read_chk(input string what, input logic [7:0] cmd, input logic [7:0] exp);
        host.read_reg(cmd, seen);
        check(what, seen, {1'b1, exp});
    endtask

    // bounded wait for the channel 0 probe start
    task automatic wait_start;
        for (int w = 0; w < 20 && probe_start[0] !== 1'b1; w++) @(posedge clk_in);
        repeat (2) @(posedge clk_in);
    endtask

    // cycle ceiling and probe start tally
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        n_start <= n_start + int'(probe_start[0] === 1'b1);
        if (cycles == 3000) begin
            errors = errors + 1;
            finish_test();
        end
    end

    initial begin
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        for (int c = 0; c < 5; c++) read_chk("reset byte", 8'h4C + 8'(c), 8'h00);
        $display("test reset done");
        foreach (rows[k]) begin
            fire(4'b0000, 4'b0011, 4'b0000, 4'b0000, rows[k]);
            fire(4'b0001, 4'b0000, 4'b0000, 4'b0000, rows[k]);
            read_chk("class ch1", 8'h4C, rows[k].exp0);
            read_chk("class ch2", 8'h4D, rows[k].exp1);
            fire(4'b0000, 4'b0000, 4'b0001, 4'b0000, rows[k]);
            @(posedge clk_in);
            check("done event", {5'b0, done_evt}, 9'h001);
        end
        $display("test class table done");
        host.write_reg(8'h4C, 8'hFF);
        fire(4'b0000, 4'b0011, 4'b0000, 4'b0000, rows[4]);
        read_chk("ro and off ch1", 8'h4C, 8'h00);
        read_chk("off ch2", 8'h4D, 8'h00);
        read_chk("unmapped", 8'h60, 8'h00);
        $display("test off and refusals done");
        host.write_reg(8'h50, 8'h1F);
        read_chk("control idle", 8'h50, 8'h1F);
        fire(4'b0001, 4'b0000, 4'b0000, 4'b0000, rows[1]);
        repeat (20) @(posedge clk_in);
        read_chk("control turn on", 8'h50, 8'h0F);
        check("starts after turn on", 9'(n_start), 9'h000);
        host.write_reg(8'h50, 8'h1F);
        wait_start();
        check("starts manual", 9'(n_start), 9'h001);
        fire(4'b0000, 4'b0000, 4'b0000, 4'b0001, rows[1]);
        @(posedge clk_in);
        check("recompute on", {5'b0, pcut}, 9'h001);
        read_chk("control cleared", 8'h50, 8'h0F);
        host.write_reg(8'h50, 8'h10);
        wait_start();
        check("starts rearmed", 9'(n_start), 9'h002);
        fire(4'b0000, 4'b0000, 4'b0000, 4'b0001, rows[1]);
        @(posedge clk_in);
        check("recompute off", {5'b0, pcut}, 9'h000);
        read_chk("control empty", 8'h50, 8'h00);
        $display("test probe control done");
        host.write_reg(8'h50, 8'hA5);
        @(posedge clk_in);
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        read_chk("control rerst", 8'h50, 8'h00);
        read_chk("class rerst", 8'h4C, 8'h00);
        $display("test second reset done");
        finish_test();
    end
endmodule
